// File: rtl/vtoa_defs.svh
// vtoa_defs.svh: constants of the two-operand vector alu.
// assumes inclusion by bare name from package and top.
`ifndef VTOA_DEFS_SVH
`define VTOA_DEFS_SVH
`define VTOA_LANES_DEF 32
`define VTOA_EXTRA_NONE 2'h0
`define VTOA_EXTRA_LITERAL 2'h1
`define VTOA_EXTRA_SHUFFLE 2'h2
`define VTOA_F32_ONE 32'h3f80_0000
`define VTOA_F32_NEG_ZERO 32'h8000_0000
`define VTOA_F32_QNAN 32'h7fc0_0000
`define VTOA_F32_QUIET 32'h0040_0000
`define VTOA_F16_EXP_ADJ 8'h70
`define VTOA_F16_DEN_EXP 103
`define VTOA_CARRY_LIMIT 33'h1_0000_0000
`define VTOA_WIN 75
`define VTOA_PROD_OFS 300
`define VTOA_ADD_OFS 174
`define VTOA_RES_OFS 101
`define VTOA_ALIGN_OFS 124
`define VTOA_ZERO_EXP (-1000)
`define VTOA_EXP_INF 255
`endif

// File: rtl/vtoa_pkg.sv
// vtoa_pkg: opcode and request types of the vector alu.
// assumes vtoa_defs.svh on the include path.
`include "vtoa_defs.svh"
`default_nettype none
package vtoa_pkg;
    typedef enum logic [5:0] {
        OP_LANE_CONDITIONAL_SELECT = 6'h00,
        OP_HALF_PAIR_DOT_ACCUMULATE,
        OP_ADD_SINGLE,
        OP_SUB_SINGLE,
        OP_SUBREV_SINGLE,
        OP_ZERO_PRODUCT_ACCUMULATE,
        OP_ZERO_PRODUCT_MULTIPLY,
        OP_MUL_SINGLE,
        OP_SIGNED_SHORT_MULTIPLY_LOW,
        OP_SIGNED_SHORT_MULTIPLY_HIGH,
        OP_UNSIGNED_SHORT_MULTIPLY_LOW,
        OP_UNSIGNED_SHORT_MULTIPLY_HIGH,
        OP_MIN_SINGLE,
        OP_MAX_SINGLE,
        OP_MIN_SIGNED,
        OP_MAX_SIGNED,
        OP_MIN_UNSIGNED,
        OP_MAX_UNSIGNED,
        OP_REVERSE_SHIFT_LEFT,
        OP_REVERSE_SHIFT_RIGHT,
        OP_REVERSE_SHIFT_ARITH,
        OP_AND,
        OP_OR,
        OP_XOR,
        OP_XNOR,
        OP_ADD_WITH_CARRY,
        OP_SUBTRACT_WITH_BORROW,
        OP_SUBREV_WITH_BORROW,
        OP_ADD_WITHOUT_CARRY,
        OP_SUB_WITHOUT_CARRY,
        OP_SUBREV_WITHOUT_CARRY,
        OP_FUSED_ACCUMULATE_SINGLE,
        OP_LITERAL_MULTIPLIER_FMA
    } vtoa_op_t;

    typedef struct packed {
        vtoa_op_t op;
        logic long_encoding;
        logic [1:0] extra_kind;
        logic [31:0] extra_word;
        logic src0_from_extra;
        logic [2:0] abs_mod;
        logic [2:0] neg_mod;
        logic ieee_mode;
        logic flush_in_denorm;
    } vtoa_req_t;
endpackage
`default_nettype wire

// File: rtl/vtoa_alu.sv
// vtoa_alu: per-lane two-operand vector alu, one cycle latency.
// assumes issue logic supplies operands, masks and the
// current destination, and writes back what this returns.
`include "vtoa_defs.svh"
`default_nettype none
module vtoa_alu #(
    parameter int LANES = `VTOA_LANES_DEF
) (
    // clock and reset
    input wire logic mclk_i,
    input wire logic rst_n_i,
    // request
    input wire logic req_valid_i,
    input wire vtoa_pkg::vtoa_req_t req_i,
    // lane operands
    input wire logic [LANES*32-1:0] src0_i,
    input wire logic [LANES*32-1:0] src1_i,
    input wire logic [LANES*32-1:0] src2_i,
    input wire logic [LANES*32-1:0] dest_i,
    input wire logic [LANES-1:0] exec_i,
    input wire logic [LANES-1:0] vcc_i,
    input wire logic [LANES-1:0] sreg_mask_i,
    // results
    output logic valid_o,
    output logic illegal_o,
    output logic [LANES*32-1:0] result_o,
    output logic [LANES-1:0] wr_lanes_o,
    output logic [LANES-1:0] mask_o,
    output logic mask_wr_o,
    output logic mask_to_scalar_o
);

    // =========================================================
    // parameter check
    if (LANES != 32 && LANES != 64) begin : g_bad_lanes
        $error("vtoa_alu: LANES must be 32 or 64");
    end

    // =========================================================
    // float helpers
    function automatic logic is_nan(input logic [31:0] x);
        return (&x[30:23]) & (|x[22:0]);
    endfunction

    function automatic logic is_inf(input logic [31:0] x);
        return (&x[30:23]) & ~(|x[22:0]);
    endfunction

    function automatic logic is_zero(input logic [31:0] x);
        return ~(|x[30:0]);
    endfunction

    function automatic logic [31:0] fmod(input logic [31:0] x, input logic ab, input logic ng);
        return {(x[31] & ~ab) ^ ng, x[30:0]};
    endfunction

    // exact half to single widening
    function automatic logic [31:0] h2f(input logic [15:0] h);
        logic [31:0] f;
        logic [23:0] w;
        int k;
        f = {h[15], 31'h0};
        k = 0;
        w = {14'h0, h[9:0]};
        if (&h[14:10]) begin
            f = {h[15], 8'hff, h[9:0], 13'h0};
        end else if (|h[14:10]) begin
            f = {h[15], {3'h0, h[14:10]} + `VTOA_F16_EXP_ADJ, h[9:0], 13'h0};
        end else if (|h[9:0]) begin
            for (int i = 0; i < 10; i++) begin
                if (h[i]) begin
                    k = i;
                end
            end
            w = w << (23 - k);
            f = {h[15], 8'(k + `VTOA_F16_DEN_EXP), w[22:0]};
        end
        return f;
    endfunction

    // single fused multiply-add, round to nearest even, denormals kept
    function automatic logic [31:0] fp_fma(input logic [31:0] a, input logic [31:0] b, input logic [31:0] c);
        logic sp, sbig, ssml, rs, g, stk, up;
        logic [23:0] ma, mb, mc, m;
        logic [47:0] pm;
        logic [74:0] big, sml, s;
        logic [75:0] s76, t;
        logic [24:0] m25;
        logic [31:0] y;
        int ea, eb, ec, ex, ey, emax, d, p, e, ee, r, ef;
        ma = {|a[30:23], a[22:0]};
        mb = {|b[30:23], b[22:0]};
        mc = {|c[30:23], c[22:0]};
        ea = (a[30:23] == 8'h00) ? 1 : int'(a[30:23]);
        eb = (b[30:23] == 8'h00) ? 1 : int'(b[30:23]);
        ec = (c[30:23] == 8'h00) ? 1 : int'(c[30:23]);
        sp = a[31] ^ b[31];
        pm = ma * mb;
        ex = (pm == 48'h0) ? `VTOA_ZERO_EXP : ea + eb - `VTOA_PROD_OFS;
        ey = (mc == 24'h0) ? `VTOA_ZERO_EXP : ec - `VTOA_ADD_OFS;
        if (ex >= ey) begin
            big = {1'b0, pm, 26'h0};
            sbig = sp;
            sml = {1'b0, mc, 50'h0};
            ssml = c[31];
            emax = ex;
            d = ex - ey;
        end else begin
            big = {1'b0, mc, 50'h0};
            sbig = c[31];
            sml = {1'b0, pm, 26'h0};
            ssml = sp;
            emax = ey;
            d = ey - ex;
        end
        // alignment shift with sticky jam into the lsb
        if (d >= `VTOA_WIN) begin
            stk = |sml;
            sml = '0;
        end else begin
            stk = |(sml << (`VTOA_WIN - d));
            sml = sml >> d;
        end
        sml[0] = sml[0] | stk;
        if (sbig == ssml) begin
            s = big + sml;
            rs = sbig;
        end else if (big >= sml) begin
            s = big - sml;
            rs = sbig;
        end else begin
            s = sml - big;
            rs = ssml;
        end
        p = 0;
        for (int i = 0; i < `VTOA_WIN; i++) begin
            if (s[i]) begin
                p = i;
            end
        end
        e = p + emax + `VTOA_RES_OFS;
        ee = (e < 1) ? 1 : e;
        r = ee - emax - `VTOA_ALIGN_OFS;
        s76 = {1'b0, s};
        if (r >= 1) begin
            t = s76 >> (r - 1);
            stk = (r - 1 >= `VTOA_WIN + 1) ? |s76 : |(s76 << (`VTOA_WIN + 1 - (r - 1)));
        end else begin
            t = s76 << (1 - r);
            stk = 1'b0;
        end
        g = t[0];
        m = t[24:1];
        up = g & (stk | m[0]);
        m25 = {1'b0, m} + {24'h0, up};
        ef = m25[24] ? ee + 1 : (m25[23] ? ee : 0);
        if (s == '0) begin
            y = {sbig & ssml, 31'h0};
        end else if (ef >= `VTOA_EXP_INF) begin
            y = {rs, 8'hff, 23'h0};
        end else begin
            y = {rs, 8'(ef), m25[24] ? m25[23:1] : m25[22:0]};
        end
        if (is_nan(a)) begin
            y = a | `VTOA_F32_QUIET;
        end else if (is_nan(b)) begin
            y = b | `VTOA_F32_QUIET;
        end else if (is_nan(c)) begin
            y = c | `VTOA_F32_QUIET;
        end else if ((is_inf(a) & is_zero(b)) | (is_zero(a) & is_inf(b))) begin
            y = `VTOA_F32_QNAN;
        end else if ((is_inf(a) | is_inf(b)) & is_inf(c) & (sp != c[31])) begin
            y = `VTOA_F32_QNAN;
        end else if (is_inf(a) | is_inf(b)) begin
            y = {sp, 8'hff, 23'h0};
        end else if (is_inf(c)) begin
            y = c;
        end
        return y;
    endfunction

    // float min/max with signed-zero ordering and nan rules
    function automatic logic [31:0] fminmax(input logic [31:0] a0, input logic [31:0] b0,
                                            input logic mx, input logic ieee, input logic flush);
        logic [31:0] a, b, ka, kb, y;
        logic pick_a;
        a = a0;
        b = b0;
        if (flush && a[30:23] == 8'h00) begin
            a = {a[31], 31'h0};
        end
        if (flush && b[30:23] == 8'h00) begin
            b = {b[31], 31'h0};
        end
        // -0 orders below +0 in this key
        ka = a[31] ? ~a : {1'b1, a[30:0]};
        kb = b[31] ? ~b : {1'b1, b[30:0]};
        pick_a = mx ? (ka > kb) : (ka < kb);
        y = pick_a ? a : b;
        if (ieee) begin
            if (is_nan(a) && !a[22]) begin
                y = a | `VTOA_F32_QUIET;
            end else if (is_nan(b) && !b[22]) begin
                y = b | `VTOA_F32_QUIET;
            end else if (is_nan(b)) begin
                y = a;
            end else if (is_nan(a)) begin
                y = b;
            end
        end else if (is_nan(b)) begin
            y = a;
        end else if (is_nan(a)) begin
            y = b;
        end
        return y;
    endfunction

    // =========================================================
    // request decode
    logic refuse;
    logic carry_op;
    logic float_op;
    logic has_lit;

    always_comb begin
        has_lit = req_i.extra_kind == `VTOA_EXTRA_LITERAL;
        refuse = req_i.op == vtoa_pkg::OP_LITERAL_MULTIPLIER_FMA &&
                 (req_i.long_encoding || !has_lit);
        carry_op = req_i.op == vtoa_pkg::OP_ADD_WITH_CARRY ||
                   req_i.op == vtoa_pkg::OP_SUBTRACT_WITH_BORROW ||
                   req_i.op == vtoa_pkg::OP_SUBREV_WITH_BORROW;
        case (req_i.op)
            vtoa_pkg::OP_LANE_CONDITIONAL_SELECT,
            vtoa_pkg::OP_ADD_SINGLE,
            vtoa_pkg::OP_SUB_SINGLE,
            vtoa_pkg::OP_SUBREV_SINGLE,
            vtoa_pkg::OP_ZERO_PRODUCT_ACCUMULATE,
            vtoa_pkg::OP_ZERO_PRODUCT_MULTIPLY,
            vtoa_pkg::OP_MUL_SINGLE,
            vtoa_pkg::OP_MIN_SINGLE,
            vtoa_pkg::OP_MAX_SINGLE,
            vtoa_pkg::OP_FUSED_ACCUMULATE_SINGLE: float_op = req_i.long_encoding;
            default: float_op = 1'b0;
        endcase
    end

    // =========================================================
    // lanes
    wire [LANES*32-1:0] next_result;
    wire [LANES-1:0] next_mask;

    for (genvar l = 0; l < LANES; l++) begin : g_lane
        logic [31:0] s0, s1, s2, x0, x1, x2, dst, res, acc;
        logic cin, cout, co_en;
        logic [32:0] sum33;
        logic signed [47:0] sprod;
        logic [47:0] uprod;
        logic [63:0] wide;

        always_comb begin
            s0 = src0_i[l*32 +: 32];
            if (req_i.extra_kind == `VTOA_EXTRA_SHUFFLE) begin
                // quad permute of the first source
                s0 = src0_i[((l / 4) * 4 + int'(req_i.extra_word[(l % 4) * 2 +: 2])) * 32 +: 32];
            end else if (has_lit && req_i.src0_from_extra) begin
                s0 = req_i.extra_word;
            end
            s1 = src1_i[l*32 +: 32];
            s2 = src2_i[l*32 +: 32];
            dst = dest_i[l*32 +: 32];
            x0 = float_op ? fmod(s0, req_i.abs_mod[0], req_i.neg_mod[0]) : s0;
            x1 = float_op ? fmod(s1, req_i.abs_mod[1], req_i.neg_mod[1]) : s1;
            x2 = float_op ? fmod(s2, req_i.abs_mod[2], req_i.neg_mod[2]) : s2;
            cin = req_i.long_encoding ? sreg_mask_i[l] : vcc_i[l];
            sprod = $signed(s0[23:0]) * $signed(s1[23:0]);
            uprod = s0[23:0] * s1[23:0];
            sum33 = '0;
            wide = '0;
            acc = '0;
            cout = 1'b0;
            co_en = 1'b0;
            case (req_i.op)
                vtoa_pkg::OP_LANE_CONDITIONAL_SELECT: res = cin ? x1 : x0;
                vtoa_pkg::OP_HALF_PAIR_DOT_ACCUMULATE: begin
                    acc = fp_fma(h2f(s0[15:0]), h2f(s1[15:0]), dst);
                    res = fp_fma(h2f(s0[31:16]), h2f(s1[31:16]), acc);
                end
                vtoa_pkg::OP_ADD_SINGLE: res = fp_fma(x0, `VTOA_F32_ONE, x1);
                vtoa_pkg::OP_SUB_SINGLE: res = fp_fma(x0, `VTOA_F32_ONE, {~x1[31], x1[30:0]});
                vtoa_pkg::OP_SUBREV_SINGLE: res = fp_fma(x1, `VTOA_F32_ONE, {~x0[31], x0[30:0]});
                vtoa_pkg::OP_ZERO_PRODUCT_ACCUMULATE:
                    res = (is_zero(x0) || is_zero(x1)) ? x2 : fp_fma(x0, x1, dst);
                vtoa_pkg::OP_ZERO_PRODUCT_MULTIPLY:
                    res = (is_zero(x0) || is_zero(x1)) ? 32'h0 : fp_fma(x0, x1, `VTOA_F32_NEG_ZERO);
                vtoa_pkg::OP_MUL_SINGLE: res = fp_fma(x0, x1, `VTOA_F32_NEG_ZERO);
                vtoa_pkg::OP_SIGNED_SHORT_MULTIPLY_LOW: res = sprod[31:0];
                vtoa_pkg::OP_SIGNED_SHORT_MULTIPLY_HIGH: begin
                    wide = {{16{sprod[47]}}, sprod};
                    res = wide[63:32];
                end
                vtoa_pkg::OP_UNSIGNED_SHORT_MULTIPLY_LOW: res = uprod[31:0];
                vtoa_pkg::OP_UNSIGNED_SHORT_MULTIPLY_HIGH: begin
                    wide = {16'h0, uprod};
                    res = wide[63:32];
                end
                vtoa_pkg::OP_MIN_SINGLE:
                    res = fminmax(x0, x1, 1'b0, req_i.ieee_mode, req_i.flush_in_denorm);
                vtoa_pkg::OP_MAX_SINGLE:
                    res = fminmax(x0, x1, 1'b1, req_i.ieee_mode, req_i.flush_in_denorm);
                vtoa_pkg::OP_MIN_SIGNED: res = ($signed(s0) < $signed(s1)) ? s0 : s1;
                vtoa_pkg::OP_MAX_SIGNED: res = ($signed(s0) >= $signed(s1)) ? s0 : s1;
                vtoa_pkg::OP_MIN_UNSIGNED: res = (s0 < s1) ? s0 : s1;
                vtoa_pkg::OP_MAX_UNSIGNED: res = (s0 >= s1) ? s0 : s1;
                vtoa_pkg::OP_REVERSE_SHIFT_LEFT: res = s1 << s0[4:0];
                vtoa_pkg::OP_REVERSE_SHIFT_RIGHT: res = s1 >> s0[4:0];
                vtoa_pkg::OP_REVERSE_SHIFT_ARITH: res = $signed(s1) >>> s0[4:0];
                vtoa_pkg::OP_AND: res = s0 & s1;
                vtoa_pkg::OP_OR: res = s0 | s1;
                vtoa_pkg::OP_XOR: res = s0 ^ s1;
                vtoa_pkg::OP_XNOR: res = ~(s0 ^ s1);
                vtoa_pkg::OP_ADD_WITH_CARRY: begin
                    sum33 = {1'b0, s0} + {1'b0, s1} + {32'h0, cin};
                    res = sum33[31:0];
                    cout = sum33 >= `VTOA_CARRY_LIMIT;
                    co_en = 1'b1;
                end
                vtoa_pkg::OP_SUBTRACT_WITH_BORROW: begin
                    res = s0 - s1 - {31'h0, cin};
                    cout = ({1'b0, s1} + {32'h0, cin}) > {1'b0, s0};
                    co_en = 1'b1;
                end
                vtoa_pkg::OP_SUBREV_WITH_BORROW: begin
                    res = s1 - s0 - {31'h0, cin};
                    cout = ({1'b0, s1} + {32'h0, cin}) > {1'b0, s0};
                    co_en = 1'b1;
                end
                vtoa_pkg::OP_ADD_WITHOUT_CARRY: res = s0 + s1;
                vtoa_pkg::OP_SUB_WITHOUT_CARRY: res = s0 - s1;
                vtoa_pkg::OP_SUBREV_WITHOUT_CARRY: res = s1 - s0;
                vtoa_pkg::OP_FUSED_ACCUMULATE_SINGLE: res = fp_fma(x0, x1, dst);
                vtoa_pkg::OP_LITERAL_MULTIPLIER_FMA: res = fp_fma(s0, req_i.extra_word, s1);
                default: res = dst;
            endcase
        end

        assign next_result[l*32 +: 32] = exec_i[l] ? res : dst;
        assign next_mask[l] = (exec_i[l] && co_en) ? cout : cin;
    end

    // =========================================================
    // status flops
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            valid_o <= 1'b0;
            illegal_o <= 1'b0;
            wr_lanes_o <= '0;
            mask_wr_o <= 1'b0;
            mask_to_scalar_o <= 1'b0;
        end else begin
            valid_o <= req_valid_i;
            illegal_o <= req_valid_i && refuse;
            wr_lanes_o <= (req_valid_i && !refuse) ? exec_i : '0;
            mask_wr_o <= req_valid_i && !refuse && carry_op;
            mask_to_scalar_o <= req_valid_i && carry_op && req_i.long_encoding;
        end
    end

    // =========================================================
    // data flops
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            result_o <= '0;
            mask_o <= '0;
        end else if (req_valid_i) begin
            result_o <= next_result;
            mask_o <= next_mask;
        end
    end

endmodule
`default_nettype wire

// File: bench/vtoa_issue_model.sv
// vtoa_issue_model: issue and register file beside the alu.
// assumes one destination word per lane and single-bit masks.
`default_nettype none
module vtoa_issue_model #(
    parameter int LANES = 32
) (
    // clock and reset
    input wire logic mclk_i,
    input wire logic rst_n_i,
    // preload from the bench
    input wire logic ld_i,
    input wire logic [31:0] ld_dest_i,
    input wire logic ld_vcc_i,
    input wire logic ld_sreg_i,
    // alu write-back
    input wire logic [LANES*32-1:0] result_i,
    input wire logic [LANES-1:0] wr_lanes_i,
    input wire logic [LANES-1:0] mask_i,
    input wire logic mask_wr_i,
    input wire logic mask_to_scalar_i,
    // state seen by the alu
    output logic [LANES*32-1:0] dest_o,
    output logic [LANES-1:0] vcc_o,
    output logic [LANES-1:0] sreg_o
);
    timeunit 1ns;
    timeprecision 1ps;
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            dest_o <= '0;
            vcc_o <= '0;
            sreg_o <= '0;
        end else if (ld_i) begin
            dest_o <= {LANES{ld_dest_i}};
            vcc_o <= {LANES{ld_vcc_i}};
            sreg_o <= {LANES{ld_sreg_i}};
        end else begin
            for (int l = 0; l < LANES; l++) begin
                if (wr_lanes_i[l]) dest_o[l*32+:32] <= result_i[l*32+:32];
            end
            if (mask_wr_i && mask_to_scalar_i) sreg_o <= mask_i;
            if (mask_wr_i && !mask_to_scalar_i) vcc_o <= mask_i;
        end
    end
endmodule
`default_nettype wire

// File: bench/vtoa_alu_checker.sv
// vtoa_alu_checker: port-level assertions of the vector alu.
// assumes the one-cycle latency of the alu top module.
`default_nettype none
module vtoa_alu_checker #(
    parameter int LANES = 32
) (
    input wire logic mclk_i,
    input wire logic rst_n_i,
    input wire logic req_valid_i,
    input wire vtoa_pkg::vtoa_req_t req_i,
    input wire logic [LANES*32-1:0] src0_i,
    input wire logic [LANES*32-1:0] src1_i,
    input wire logic [LANES-1:0] exec_i,
    input wire logic [LANES-1:0] vcc_i,
    input wire logic valid_o,
    input wire logic illegal_o,
    input wire logic [LANES*32-1:0] result_o,
    input wire logic [LANES-1:0] wr_lanes_o,
    input wire logic [LANES-1:0] mask_o,
    input wire logic mask_wr_o,
    input wire logic mask_to_scalar_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // ====================================
    // helpers
    wire logic lit = req_i.op == vtoa_pkg::OP_LITERAL_MULTIPLIER_FMA;
    wire logic cy = req_i.op == vtoa_pkg::OP_ADD_WITH_CARRY;
    wire logic nc = req_i.op inside {vtoa_pkg::OP_ADD_WITHOUT_CARRY, vtoa_pkg::OP_SUB_WITHOUT_CARRY,
        vtoa_pkg::OP_SUBREV_WITHOUT_CARRY};
    wire logic noext = req_valid_i && req_i.extra_kind == 2'h0 && !req_i.src0_from_extra;
    default clocking @(posedge mclk_i); endclocking
    default disable iff (!rst_n_i);
    // ====================================
    // assertions
    chk_valid_latency: assert property (req_valid_i |=> valid_o) else $error("no answer");
    chk_idle_quiet: assert property (!req_valid_i |=> !valid_o && wr_lanes_o == '0 && !mask_wr_o)
        else $error("output without request");
    chk_lane_enable: assert property (req_valid_i && !lit |=> wr_lanes_o == $past(exec_i) && !illegal_o)
        else $error("lane enables wrong");
    chk_fma_refuse: assert property (req_valid_i && lit && req_i.long_encoding |=> illegal_o && wr_lanes_o == '0)
        else $error("long literal fma accepted");
    chk_nocarry_mask: assert property (req_valid_i && nc |=> !mask_wr_o) else $error("mask touched");
    chk_carry_dest: assert property (req_valid_i && cy |=> mask_wr_o && mask_to_scalar_o == $past(req_i.long_encoding))
        else $error("carry destination wrong");
    chk_select_lane: assert property (noext && !req_i.long_encoding && req_i.op == vtoa_pkg::OP_LANE_CONDITIONAL_SELECT
        |=> result_o[31:0] == ($past(vcc_i[0]) ? $past(src1_i[31:0]) : $past(src0_i[31:0]))) else $error("select");
    chk_xnor_word: assert property (noext && req_i.op == vtoa_pkg::OP_XNOR
        |=> result_o[31:0] == ~($past(src0_i[31:0]) ^ $past(src1_i[31:0]))) else $error("xnor");
    chk_shift_count: assert property (noext && req_i.op == vtoa_pkg::OP_REVERSE_SHIFT_LEFT
        |=> result_o[31:0] == $past(src1_i[31:0]) << $past(src0_i[4:0])) else $error("shift");
    chk_carry_out: assert property (noext && cy && !req_i.long_encoding && exec_i[0]
        |=> mask_o[0] == ({1'b0, $past(src0_i[31:0])} + $past(src1_i[31:0]) + $past(vcc_i[0]) >= 33'h100000000))
        else $error("carry out");
    cover property (req_valid_i && cy && req_i.long_encoding);
    cover property (req_valid_i && lit && req_i.long_encoding);
    cover property (noext && req_i.op == vtoa_pkg::OP_LANE_CONDITIONAL_SELECT && vcc_i[0]);
endmodule
bind vtoa_alu vtoa_alu_checker #(.LANES(LANES)) u_chk (.mclk_i, .rst_n_i, .req_valid_i, .req_i, .src0_i, .src1_i,
    .exec_i, .vcc_i, .valid_o, .illegal_o, .result_o, .wr_lanes_o, .mask_o, .mask_wr_o, .mask_to_scalar_o);
`default_nettype wire

// File: bench/tb_vector_two_operand_alu_ops.sv
// tb_vector_two_operand_alu_ops: directed checks of the vector alu.
// assumes the issue model feeds destination and masks.
`default_nettype none
module tb_vector_two_operand_alu_ops;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int LANES = 32;
    logic mclk_i = 1'b0, rst_n_i = 1'b0, req_valid_i = 1'b0, ld = 1'b0, ldv = 1'b0, lds = 1'b0;
    logic [31:0] ldd = '0;
    vtoa_pkg::vtoa_req_t req_i = '0;
    logic [LANES*32-1:0] src0_i = '0, src1_i = '0, src2_i = '0, dest, result_o;
    logic [LANES-1:0] exec_i = LANES'(3'h5), vcc, sreg, wr_lanes_o, mask_o;
    logic valid_o, illegal_o, mask_wr_o, mask_to_scalar_o;
    int miscompares = 0, checked = 0;
    always #4 mclk_i = ~mclk_i;
    vtoa_alu #(.LANES(LANES)) DUT (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .req_valid_i(req_valid_i), .req_i(req_i),
        .src0_i(src0_i), .src1_i(src1_i), .src2_i(src2_i), .dest_i(dest), .exec_i(exec_i), .vcc_i(vcc),
        .sreg_mask_i(sreg), .valid_o(valid_o), .illegal_o(illegal_o), .result_o(result_o),
        .wr_lanes_o(wr_lanes_o), .mask_o(mask_o), .mask_wr_o(mask_wr_o), .mask_to_scalar_o(mask_to_scalar_o));
    vtoa_issue_model #(.LANES(LANES)) u_model (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .ld_i(ld), .ld_dest_i(ldd),
        .ld_vcc_i(ldv), .ld_sreg_i(lds), .result_i(result_o), .wr_lanes_i(wr_lanes_o), .mask_i(mask_o),
        .mask_wr_i(mask_wr_o), .mask_to_scalar_i(mask_to_scalar_o), .dest_o(dest), .vcc_o(vcc), .sreg_o(sreg));
    // ====================================
    // tasks
    task automatic tally_and_finish();
        if (miscompares == 0 && checked > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task automatic chk(input logic ok, input string s);
        checked++;
        if (!ok) begin
            miscompares++;
            $display("[ERR] %0t %s", $time, s);
        end
    endtask
    // f: long ieee flush abs0neg1 src0_lit kind[1:0]; m: mask_wr mask_val sreg vcc; c is also the extra word
    task automatic t(input logic [5:0] o, input logic [6:0] f, input logic [3:0] m, input logic [31:0] a, b, c, e);
        logic il;
        il = (o == 6'h20) && (f[6] || f[1:0] != 2'h1);
        @(posedge mclk_i);
        ld <= 1'b1;
        ldd <= c;
        ldv <= m[0];
        lds <= m[1];
        @(posedge mclk_i);
        ld <= 1'b0;
        req_valid_i <= 1'b1;
        req_i <= '{op: vtoa_pkg::vtoa_op_t'(o), long_encoding: f[6], extra_kind: f[1:0], extra_word: c,
            src0_from_extra: f[2], abs_mod: {2'h0, f[3]}, neg_mod: {1'b0, f[3], 1'b0},
            ieee_mode: f[5], flush_in_denorm: f[4]};
        for (int l = 0; l < LANES; l++) src0_i[l*32+:32] <= a + 32'(l);
        src1_i <= {LANES{b}};
        src2_i <= {LANES{c}};
        @(posedge mclk_i);
        req_valid_i <= 1'b0;
        #1;
        chk(valid_o === 1'b1 && illegal_o === il && wr_lanes_o === ({LANES{!il}} & exec_i), "status");
        chk(mask_wr_o === m[3] && mask_to_scalar_o === (m[3] & f[6]), "mask strobe");
        if (m[3]) chk(mask_o[0] === m[2] && mask_o[1] === (f[6] ? m[1] : m[0]), "mask value");
        if (!il) chk(result_o[31:0] === e, "result");
        @(posedge mclk_i);
        #1;
        chk(dest[31:0] === (il ? c : e) && dest[63:32] === c, "write-back");
    endtask
    // ====================================
    // sequence
    initial begin
        repeat (2) @(posedge mclk_i);
        rst_n_i <= 1'b1;
        t(6'h00, 7'h00, 4'h1, 32'h1, 32'h2, 32'h0, 32'h2);
        t(6'h00, 7'h00, 4'h0, 32'h1, 32'h2, 32'h0, 32'h1);
        t(6'h00, 7'h48, 4'h2, 32'h1, 32'h3f800000, 32'h0, 32'hbf800000);
        t(6'h01, 7'h00, 4'h0, 32'h40003c00, 32'h40003c00, 32'h3f800000, 32'h40c00000);
        t(6'h02, 7'h00, 4'h0, 32'h1, 32'h1, 32'h0, 32'h2);
        t(6'h03, 7'h00, 4'h0, 32'h40000000, 32'h3f800000, 32'h0, 32'h3f800000);
        t(6'h04, 7'h00, 4'h0, 32'h40000000, 32'h3f800000, 32'h0, 32'hbf800000);
        t(6'h06, 7'h00, 4'h0, 32'h0, 32'h7f800000, 32'h5, 32'h0);
        t(6'h05, 7'h00, 4'h0, 32'h80000000, 32'h7fc00000, 32'h12345678, 32'h12345678);
        t(6'h05, 7'h00, 4'h0, 32'h3f800000, 32'h3f800000, 32'h3f800000, 32'h40000000);
        t(6'h08, 7'h00, 4'h0, 32'h01ffffff, 32'h2, 32'h0, 32'hfffffffe);
        t(6'h0a, 7'h00, 4'h0, 32'h00ffffff, 32'h2, 32'h0, 32'h01fffffe);
        t(6'h09, 7'h00, 4'h0, 32'h00ffffff, 32'h2, 32'h0, 32'hffffffff);
        t(6'h0b, 7'h00, 4'h0, 32'h00800000, 32'h00800000, 32'h0, 32'h00004000);
        t(6'h0c, 7'h00, 4'h0, 32'h0, 32'h80000000, 32'h0, 32'h80000000);
        t(6'h0d, 7'h00, 4'h0, 32'h80000000, 32'h0, 32'h0, 32'h0);
        t(6'h0c, 7'h00, 4'h0, 32'h7fc00000, 32'h3f800000, 32'h0, 32'h3f800000);
        t(6'h0d, 7'h20, 4'h0, 32'h3f800000, 32'h7f800001, 32'h0, 32'h7fc00001);
        t(6'h0d, 7'h00, 4'h0, 32'h1, 32'h0, 32'h0, 32'h1);
        t(6'h0d, 7'h10, 4'h0, 32'h1, 32'h0, 32'h5, 32'h0);
        t(6'h0e, 7'h00, 4'h0, 32'hffffffff, 32'h1, 32'h0, 32'hffffffff);
        t(6'h10, 7'h00, 4'h0, 32'hffffffff, 32'h1, 32'h0, 32'h1);
        t(6'h0f, 7'h00, 4'h0, 32'hffffffff, 32'h1, 32'h0, 32'h1);
        t(6'h12, 7'h00, 4'h0, 32'h24, 32'h1, 32'h0, 32'h10);
        t(6'h13, 7'h00, 4'h0, 32'h21, 32'h80000000, 32'h0, 32'h40000000);
        t(6'h14, 7'h00, 4'h0, 32'h3f, 32'h80000000, 32'h0, 32'hffffffff);
        t(6'h18, 7'h48, 4'h0, 32'hf0f0ff00, 32'hff00f0f0, 32'h0, 32'hf00ff00f);
        t(6'h15, 7'h05, 4'h0, 32'h0, 32'h12345678, 32'h0000ffff, 32'h00005678);
        t(6'h19, 7'h00, 4'hd, 32'hffffffff, 32'h0, 32'h0, 32'h0);
        t(6'h1a, 7'h00, 4'hd, 32'h0, 32'h0, 32'h0, 32'hffffffff);
        t(6'h1b, 7'h00, 4'hc, 32'h1, 32'h5, 32'h0, 32'h4);
        t(6'h19, 7'h40, 4'ha, 32'h1, 32'h1, 32'h0, 32'h3);
        t(6'h1c, 7'h00, 4'h1, 32'hffffffff, 32'h2, 32'h0, 32'h1);
        t(6'h1e, 7'h02, 4'h0, 32'h10, 32'h20, 32'h1, 32'h0f);
        t(6'h1f, 7'h00, 4'h0, 32'h3f800000, 32'h40000000, 32'h3f800000, 32'h40400000);
        t(6'h20, 7'h01, 4'h0, 32'h3f800000, 32'h3f800000, 32'h40000000, 32'h40400000);
        t(6'h20, 7'h41, 4'h0, 32'h3f800000, 32'h3f800000, 32'h40000000, 32'h0);
        t(6'h06, 7'h48, 4'h0, 32'hc0000000, 32'h40400000, 32'h0, 32'hc0c00000);
        t(6'h07, 7'h00, 4'h0, 32'h40000000, 32'h40400000, 32'h0, 32'h40c00000);
        t(6'h16, 7'h00, 4'h0, 32'hf0, 32'h0f, 32'h0, 32'hff);
        t(6'h17, 7'h00, 4'h0, 32'hff, 32'h0f, 32'h0, 32'hf0);
        t(6'h11, 7'h00, 4'h0, 32'hffffffff, 32'h1, 32'h0, 32'hffffffff);
        t(6'h1d, 7'h00, 4'h1, 32'h1, 32'h2, 32'h0, 32'hffffffff);
        tally_and_finish();
    end
endmodule
`default_nettype wire
